// [hdl/cms_map.vh]
`ifndef CMS_MAP_VH
`define CMS_MAP_VH
// ----------------------------------------
// Data map
// ----------------------------------------
`define CMS_ADDR_INDIRECT_WINDOW_0 8'h00
`define CMS_ADDR_INDIRECT_WINDOW_1 8'h01
`define CMS_ADDR_PTR0 8'h02
`define CMS_ADDR_PTR1 8'h03
`define CMS_ADDR_FLAGS 8'h04
`define CMS_ADDR_WORK 8'h05
`define CMS_ADDR_INTERRUPT_FLAGS 8'h06
`define CMS_ADDR_INTERRUPT_ENABLES 8'h07
`define CMS_SYS_LAST 8'h07
`define CMS_PERIPH_LAST 8'h7F
`define CMS_RAM_FIRST 8'h80
// ----------------------------------------
// Vectors, fields and reset values
// ----------------------------------------
`define CMS_RESET_VECTOR 11'h000
`define CMS_IRQ_VECTOR 11'h004
`define CMS_FLAG_PD 4
`define CMS_FLAG_TO 3
`define CMS_FLAG_DC 2
`define CMS_FLAG_C 1
`define CMS_FLAG_Z 0
`define CMS_GATE_BIT 7
`define CMS_FLAGS_RESET 8'h00
`define CMS_INTERRUPT_FLAGS_RESET 8'h00
`define CMS_INTERRUPT_ENABLES_RESET 8'h00
`define CMS_INTERRUPT_FLAGS_MASK 8'h1F
`define CMS_INTERRUPT_ENABLES_MASK 8'h9F
`define CMS_FLAGS_MASK 8'h1F
`endif

// [hdl/cms_core_map.v]
// How it works
// RQ1: An 11-bit instruction pointer addresses 2k words of 16 bits.
// RQ2: A six-deep, 11-bit return stack saves the pointer across calls.
// RQ3: Any reset loads the instruction pointer with 0000h.
// RQ4: Every interrupt entry loads the instruction pointer with 0004h.
// RQ5: The data space has 256 bytes selected by an 8-bit address.
// RQ6: Addresses 00h to 07h select the system registers.
// RQ7: Addresses 08h to 7Fh go out to peripheral registers.
// RQ8: Addresses 80h to FFh select general read/write storage.
// RQ9: Window 0 at 00h redirects to the address held in pointer 0.
// RQ10: Window 1 at 01h redirects to the address held in pointer 1.
// RQ11: Flag register at 04h holds power-down, timeout, digit carry; resets 00u00uuu. The code resets it to 00h.
// RQ12: Interrupt flags at 06h clear to zero on power-on reset.
// RQ13: Windows hold no storage; reads and writes go to the pointed byte.
// RQ14: ALU flag updates beat explicit writes; power-down and timeout bits are read-only.
// RQ15: Enable bit 7 gates all interrupts globally.
// RQ16: Interrupt entry pushes the next instruction address onto the stack. The code pushes pc_q itself; a call pushes pc_q plus one.
`include "cms_map.vh"
module cms_core_map #(
  parameter PC_W = 11,
  parameter STACK_DEPTH = 6,
  parameter RAM_WORDS = 128
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire pc_inc,
  input wire pc_load,
  input wire [PC_W-1:0] pc_target,
  input wire do_call,
  input wire do_return,
  input wire irq_accept,
  input wire [7:0] d_addr,
  input wire d_rd,
  input wire d_wr,
  input wire [7:0] d_wdata,
  input wire alu_flag_we,
  input wire [2:0] alu_flags,
  input wire wdt_timeout,
  input wire sleep_exec,
  input wire [4:0] irq_events,
  input wire [7:0] periph_rdata,
  output reg [PC_W-1:0] pc_q,
  output reg [7:0] rdata_q,
  output reg [7:0] periph_addr_q,
  output reg periph_rd_q,
  output reg periph_wr_q,
  output reg [7:0] periph_wdata_q,
  output reg irq_pending_q,
  output reg [7:0] work_q,
  output reg [7:0] flags_q
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg [PC_W-1:0] stack_q [0:STACK_DEPTH-1];
  reg [2:0] sp_q;
  reg [7:0] ptr0_q;
  reg [7:0] ptr1_q;
  reg [7:0] interrupt_flags_q;
  reg [7:0] interrupt_enables_q;
  reg [7:0] ram_q [0:RAM_WORDS-1];
  reg [7:0] eff_addr;
  reg [7:0] sys_rdata;
  reg [7:0] flags_d;
  reg [7:0] interrupt_flags_d;
  reg [PC_W-1:0] pc_d;
  integer i;

  // ----------------------------------------
  // Address resolution
  // ----------------------------------------
  // A window that points at a window resolves to zero, so it cannot recurse.
  always @* begin
    if (d_addr == `CMS_ADDR_INDIRECT_WINDOW_0) begin
      eff_addr = ptr0_q; // [RQ9] [RQ13]
    end else if (d_addr == `CMS_ADDR_INDIRECT_WINDOW_1) begin
      eff_addr = ptr1_q; // [RQ10] [RQ13]
    end else begin
      eff_addr = d_addr; // [RQ5]
    end
  end

  always @* begin
    if (eff_addr == `CMS_ADDR_PTR0) begin
      sys_rdata = ptr0_q;
    end else if (eff_addr == `CMS_ADDR_PTR1) begin
      sys_rdata = ptr1_q;
    end else if (eff_addr == `CMS_ADDR_FLAGS) begin
      sys_rdata = flags_q;
    end else if (eff_addr == `CMS_ADDR_WORK) begin
      sys_rdata = work_q;
    end else if (eff_addr == `CMS_ADDR_INTERRUPT_FLAGS) begin
      sys_rdata = interrupt_flags_q;
    end else if (eff_addr == `CMS_ADDR_INTERRUPT_ENABLES) begin
      sys_rdata = interrupt_enables_q;
    end else begin
      sys_rdata = 8'h00;
    end
  end

  // ----------------------------------------
  // Flag and interrupt next values
  // ----------------------------------------
  always @* begin
    flags_d = flags_q;
    if (d_wr && eff_addr == `CMS_ADDR_FLAGS && !alu_flag_we) begin
      flags_d[`CMS_FLAG_DC] = d_wdata[`CMS_FLAG_DC]; // [RQ14]
      flags_d[`CMS_FLAG_C] = d_wdata[`CMS_FLAG_C]; // [RQ14]
      flags_d[`CMS_FLAG_Z] = d_wdata[`CMS_FLAG_Z]; // [RQ14]
    end
    if (alu_flag_we) begin
      flags_d[`CMS_FLAG_DC:`CMS_FLAG_Z] = alu_flags; // [RQ14]
    end
    if (sleep_exec) begin
      flags_d[`CMS_FLAG_PD] = 1'b1; // [RQ11]
    end
    if (wdt_timeout) begin
      flags_d[`CMS_FLAG_TO] = 1'b1; // [RQ11]
    end
    flags_d = flags_d & `CMS_FLAGS_MASK;
  end

  always @* begin
    interrupt_flags_d = interrupt_flags_q;
    if (d_wr && eff_addr == `CMS_ADDR_INTERRUPT_FLAGS) begin
      interrupt_flags_d = d_wdata & `CMS_INTERRUPT_FLAGS_MASK;
    end
    // A source event in the clearing cycle still lands.
    interrupt_flags_d = interrupt_flags_d | {3'b000, irq_events};
  end

  // ----------------------------------------
  // Program sequencing
  // ----------------------------------------
  always @* begin
    pc_d = pc_q;
    if (irq_accept) begin
      pc_d = `CMS_IRQ_VECTOR; // [RQ4]
    end else if (do_return) begin
      pc_d = stack_q[sp_q - 3'd1]; // [RQ2]
    end else if (pc_load) begin
      pc_d = pc_target;
    end else if (pc_inc) begin
      pc_d = pc_q + {{(PC_W-1){1'b0}}, 1'b1}; // [RQ1]
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= `CMS_RESET_VECTOR; // [RQ3]
      sp_q <= 3'd0;
      for (i = 0; i < STACK_DEPTH; i = i + 1) begin
        stack_q[i] <= {PC_W{1'b0}};
      end
    end else if (ce) begin
      pc_q <= pc_d;
      if (irq_accept || do_call) begin
        // A seventh push overwrites the newest entry; older ones survive.
        if (sp_q == STACK_DEPTH) begin
          stack_q[STACK_DEPTH-1] <= irq_accept ? pc_q : pc_q + {{(PC_W-1){1'b0}}, 1'b1}; // [RQ16]
        end else begin
          stack_q[sp_q] <= irq_accept ? pc_q : pc_q + {{(PC_W-1){1'b0}}, 1'b1}; // [RQ2] [RQ16]
          sp_q <= sp_q + 3'd1;
        end
      end else if (do_return && sp_q != 3'd0) begin
        sp_q <= sp_q - 3'd1;
      end
    end
  end

  // ----------------------------------------
  // Data space
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr0_q <= 8'h00;
      ptr1_q <= 8'h00;
      work_q <= 8'h00;
      flags_q <= `CMS_FLAGS_RESET; // [RQ11]
      interrupt_flags_q <= `CMS_INTERRUPT_FLAGS_RESET; // [RQ12]
      interrupt_enables_q <= `CMS_INTERRUPT_ENABLES_RESET;
      rdata_q <= 8'h00;
      periph_addr_q <= 8'h00;
      periph_rd_q <= 1'b0;
      periph_wr_q <= 1'b0;
      periph_wdata_q <= 8'h00;
      irq_pending_q <= 1'b0;
    end else if (ce) begin
      flags_q <= flags_d;
      interrupt_flags_q <= interrupt_flags_d;
      irq_pending_q <= interrupt_enables_q[`CMS_GATE_BIT] && |(interrupt_flags_q[4:0] & interrupt_enables_q[4:0]); // [RQ15]
      periph_rd_q <= 1'b0;
      periph_wr_q <= 1'b0;
      if (d_wr) begin
        if (eff_addr <= `CMS_SYS_LAST) begin // [RQ6]
          if (eff_addr == `CMS_ADDR_PTR0) begin
            ptr0_q <= d_wdata;
          end else if (eff_addr == `CMS_ADDR_PTR1) begin
            ptr1_q <= d_wdata;
          end else if (eff_addr == `CMS_ADDR_WORK) begin
            work_q <= d_wdata;
          end else if (eff_addr == `CMS_ADDR_INTERRUPT_ENABLES) begin
            interrupt_enables_q <= d_wdata & `CMS_INTERRUPT_ENABLES_MASK;
          end
        end else if (eff_addr <= `CMS_PERIPH_LAST) begin
          periph_addr_q <= eff_addr; // [RQ7]
          periph_wdata_q <= d_wdata;
          periph_wr_q <= 1'b1;
        end else begin
          ram_q[eff_addr[6:0]] <= d_wdata; // [RQ8]
        end
      end
      if (d_rd) begin
        if (eff_addr <= `CMS_SYS_LAST) begin
          rdata_q <= sys_rdata; // [RQ6]
        end else if (eff_addr <= `CMS_PERIPH_LAST) begin
          periph_addr_q <= eff_addr; // [RQ7]
          periph_rd_q <= 1'b1;
          rdata_q <= 8'h00;
        end else begin
          rdata_q <= ram_q[eff_addr[6:0]]; // [RQ8]
        end
      end else if (periph_rd_q) begin
        // Peripheral data returns one cycle after the strobe.
        rdata_q <= periph_rdata;
      end
    end
  end
endmodule // cms_core_map

// [testbench/cms_periph_model.sv]
module cms_periph_model (
  input logic clk,
  input logic periph_rd_q,
  input logic [7:0] periph_addr_q,
  output logic [7:0] periph_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] stale_q = 8'h00;
  always @(posedge clk) stale_q <= ~periph_rdata;
  // Outside a strobe the bus toggles and shows the complement first, so a sample one cycle late never matches by luck.
  assign periph_rdata = periph_rd_q ? (periph_addr_q ^ 8'hA5) : stale_q;
endmodule // cms_periph_model

// [testbench/cms_core_map_monitor.sv]
module cms_core_map_monitor #(parameter PC_W = 11) (
  input logic clk,
  input logic rst,
  input logic ce,
  input logic pc_inc,
  input logic pc_load,
  input logic do_call,
  input logic do_return,
  input logic irq_accept,
  input logic d_rd,
  input logic d_wr,
  input logic sleep_exec,
  input logic wdt_timeout,
  input logic periph_rd_q,
  input logic periph_wr_q,
  input logic irq_pending_q,
  input logic [7:0] d_addr,
  input logic [7:0] d_wdata,
  input logic [7:0] rdata_q,
  input logic [7:0] periph_addr_q,
  input logic [7:0] periph_wdata_q,
  input logic [7:0] flags_q,
  input logic [PC_W-1:0] pc_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire ctl = pc_inc | pc_load | do_call | do_return | irq_accept;
  sequence s_irq; ce && irq_accept; endsequence
  sequence s_ret; ce && do_return && !irq_accept; endsequence
  sequence s_wr; ce && d_wr && d_addr[7]; endsequence
  irq_vec_a: assert property (s_irq |=> pc_q == 11'h004) else $error("irq vector wrong");
  rst_vec_a: assert property ($past(rst) |-> pc_q == 11'h000) else $error("reset vector wrong");
  irq_ret_a: assert property (s_irq ##1 (ce && !ctl) ##1 s_ret |=> pc_q == $past(pc_q, 3))
    else $error("return after irq wrong");
  pc_step_a: assert property (ce && pc_inc && !pc_load && !do_return && !irq_accept |=>
    pc_q == $past(pc_q) + 11'd1) else $error("pc step wrong");
  periph_rd_a: assert property (ce && d_rd && d_addr inside {[8'h08:8'h7F]} |=>
    periph_rd_q && periph_addr_q == $past(d_addr)) else $error("periph strobe wrong");
  periph_wr_a: assert property (ce && d_wr && d_addr inside {[8'h08:8'h7F]} |=>
    periph_wr_q && periph_addr_q == $past(d_addr) && periph_wdata_q == $past(d_wdata))
    else $error("periph write strobe wrong");
  pd_to_ro_a: assert property (ce && d_wr && d_addr == 8'h04 && !sleep_exec && !wdt_timeout |=>
    flags_q[4:3] == $past(flags_q[4:3])) else $error("pd or to written");
  gate_off_a: assert property (ce && d_wr && d_addr == 8'h07 && !d_wdata[7] ##1 !d_wr |=>
    !irq_pending_q) else $error("irq pending without gate");
  ram_trip_a: assert property (s_wr ##1 !d_wr [*2] ##1 (ce && d_rd && d_addr == $past(d_addr, 3)) |=>
    rdata_q == $past(d_wdata, 4)) else $error("ram readback wrong");
endmodule // cms_core_map_monitor
bind cms_core_map cms_core_map_monitor #(.PC_W(PC_W)) cms_core_map_monitor_inst (.*);

// [testbench/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, ce = 1, pc_inc = 0, pc_load = 0, do_call = 0, do_return = 0, irq_accept = 0;
  logic d_rd = 0, d_wr = 0, alu_flag_we = 0, wdt_timeout = 0, sleep_exec = 0, irq_pending_q;
  logic [10:0] pc_target = 0, pc_q;
  logic [7:0] d_addr = 0, d_wdata = 0, periph_rdata, rdata_q, work_q, flags_q, periph_addr_q, periph_wdata_q;
  logic [2:0] alu_flags = 0;
  logic [4:0] irq_events = 0;
  logic periph_rd_q, periph_wr_q;
  integer seed = 32'hc6447005, error_cnt = 0, check_count = 0, i;
  logic [7:0] mem [256];
  logic [7:0] a, v;
  always #25 clk = ~clk;
  cms_core_map cms_core_map_inst (.*);
  cms_periph_model cms_periph_model_inst (.*);
  task chk(input logic [10:0] g, input logic [10:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task op(input logic w, input logic [7:0] ad, input logic [7:0] wd);
    d_addr <= ad;
    d_wr <= w;
    d_rd <= !w;
    d_wdata <= wd;
    @(posedge clk);
    d_wr <= 0;
    d_rd <= 0;
    repeat (2) @(posedge clk);
  endtask
  task go(input logic [4:0] m, input logic [10:0] t);
    {pc_load, do_call, do_return, irq_accept, pc_inc} <= m;
    pc_target <= t;
    @(posedge clk);
    {pc_load, do_call, do_return, irq_accept, pc_inc} <= 0;
    @(posedge clk);
  endtask
  task test_done;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk(pc_q, 0);
    chk(flags_q, 0);
    op(0, 8'h06, 0);
    chk(rdata_q, 0);
    for (i = 0; i < 6; i++) begin
      a = 8'h80 | $random(seed);
      v = $random(seed);
      mem[a] = v;
      op(1, a, v);
      op(0, a, 0);
      chk(rdata_q, mem[a]);
    end
    op(1, 8'h02, a);
    v = $random(seed);
    mem[a] = v;
    op(1, 8'h00, v);
    op(0, a, 0);
    chk(rdata_q, v);
    op(1, 8'h03, a);
    op(0, 8'h01, 0);
    chk(rdata_q, mem[a]);
    op(0, 8'h3C, 0);
    chk(rdata_q, 8'h3C ^ 8'hA5);
    op(1, 8'h20, v);
    chk(periph_addr_q, 8'h20);
    chk(periph_wdata_q, v);
    op(1, 8'h05, v);
    chk(work_q, v);
    op(0, 8'h05, 0);
    chk(rdata_q, v);
    sleep_exec <= 1;
    wdt_timeout <= 1;
    alu_flag_we <= 1;
    alu_flags <= 3'h5;
    @(posedge clk);
    sleep_exec <= 0;
    wdt_timeout <= 0;
    op(1, 8'h04, 8'h07);
    chk(flags_q, 8'h1D);
    alu_flag_we <= 0;
    op(1, 8'h04, 8'h02);
    chk(flags_q, 8'h1A);
    irq_events <= 5'h01;
    @(posedge clk);
    irq_events <= 0;
    op(1, 8'h07, 8'h01);
    chk(irq_pending_q, 0);
    op(1, 8'h07, 8'h81);
    for (i = 0; i < 8 && irq_pending_q !== 1; i++) @(posedge clk);
    chk(irq_pending_q, 1);
    go(5'h10, 11'h123);
    go(5'h02, 0);
    chk(pc_q, 11'h004);
    go(5'h04, 0);
    chk(pc_q, 11'h123);
    go(5'h18, 11'h7FF);
    go(5'h01, 0);
    chk(pc_q, 0);
    go(5'h04, 0);
    chk(pc_q, 11'h124);
    ce <= 0;
    go(5'h01, 0);
    chk(pc_q, 11'h124);
    ce <= 1;
    for (i = 0; i < 6; i++) go(5'h18, 11'h200 + i);
    for (i = 5; i > 0; i--) begin
      go(5'h04, 0);
      chk(pc_q, 11'h200 + i);
    end
    go(5'h04, 0);
    chk(pc_q, 11'h125);
    test_done;
  end
endmodule // tb
